// ==== rtl/wake_phy_pkg.sv ====
package wake_phy_pkg;
    // Clock and management timing.
    localparam int CLK_PERIOD_NS   = 25;
    localparam int MDC_PERIOD_NS   = 320;
    localparam int MDC_HALF_CYC    = (MDC_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STATUS_LIMIT_US = 300;

    // Register indices; the byte address is four times the index.
    localparam int             ADDR_W          = 12;
    localparam logic [7:0]     IDX_WAKE_CONFIG = 8'h56;
    localparam logic [7:0]     IDX_PM_STATUS   = 8'h58;
    localparam logic [7:0]     IDX_PHY_ACCESS  = 8'h60;
    localparam logic [7:0]     IDX_PHY_STATUS  = 8'h6c;
    localparam logic [7:0]     IDX_RX_SIZE     = 8'hda;

    // Field positions.
    localparam int BCAST_WAKE_BIT = 6;
    localparam int MCAST_WAKE_BIT = 5;
    localparam int UCAST_WAKE_BIT = 4;
    localparam int WAKE_SIG_BIT   = 1;
    localparam int PM_POLICY_BIT  = 0;
    localparam int PM_FLAG_BIT    = 0;
    localparam int PHY_FLAG_BIT   = 31;
    localparam int PHY_IDX_LSB    = 16;
    localparam int PHY_IDX_W      = 5;
    localparam int PHY_VAL_W      = 16;
    localparam int LINK_STAT_W    = 7;
    localparam int RX_SIZE_W      = 14;

    // Management frame layout, sent most significant bit first.
    localparam logic [31:0] MDIO_PREAMBLE = 32'hffffffff;
    localparam logic [1:0]  MDIO_START    = 2'h1;
    localparam logic [1:0]  MDIO_OP_RD    = 2'h2;
    localparam logic [1:0]  MDIO_OP_WR    = 2'h1;
    localparam logic [1:0]  MDIO_TA_WR    = 2'h2;
    localparam logic [1:0]  MDIO_TA_RD    = 2'h0;
    localparam logic [5:0]  BIT_LAST      = 6'h3f;
    localparam logic [5:0]  BIT_RD_DRIVE  = 6'h2e;
    localparam logic [5:0]  BIT_DATA      = 6'h30;

    // Background poll list, slot 0 in the low bits.
    localparam int          POLL_SLOTS       = 6;
    localparam logic [2:0]  POLL_LAST_SLOT   = 3'h5;
    localparam logic [2:0]  POLL_STATUS_SLOT = 3'h5;
    localparam logic [29:0] POLL_LIST = {5'h11, 5'h0a, 5'h05, 5'h04, 5'h01, 5'h00};

    typedef enum logic [1:0] {
        MDIO_IDLE  = 2'h0,
        MDIO_SHIFT = 2'h1,
        MDIO_DONE  = 2'h3
    } mdio_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0]       pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

    typedef struct packed {
        logic valid;
        logic mask_dest_only;
        logic dest_bcast;
        logic dest_mcast;
        logic dest_own;
    } wake_frame_s;

    typedef struct packed {
        logic                 done;
        logic [RX_SIZE_W-1:0] len;
        logic                 crc_err;
    } rx_end_s;

    typedef struct packed {
        logic valid;
        logic oversize;
        logic err_summary;
        logic good;
    } rx_status_s;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    function automatic logic [63:0] mdio_frame(input logic wr, input logic [4:0] phy,
                                               input logic [4:0] rg, input logic [15:0] val);
        return {MDIO_PREAMBLE, MDIO_START, wr ? MDIO_OP_WR : MDIO_OP_RD, phy, rg,
                wr ? MDIO_TA_WR : MDIO_TA_RD, wr ? val : 16'h0000};
    endfunction
endpackage

// ==== rtl/wake_phy_access_regs.sv ====
// Functional notes
// R1: Broadcast wake enable accepts destination-only all-ones mask frames as wake-up.
// R2: Multicast wake enable accepts destination-only multicast mask frames as wake-up.
// R3: Unicast wake enable accepts destination-only own-address mask frames as wake-up.
// R4: Broadcast, multicast and unicast wake enables are zero after power-on.
// R5: Wake output is driven only while the wake signal enable is set.
// R6: Policy bit set lets bus reset or software clear the status flag.
// R7: Wake signal enable and status policy load from the EEPROM byte.
// R8: Write with flag set performs PHY write; flag clears when done.
// R9: Write with flag clear performs PHY read; flag sets when data is fetched.
// R10: Target PHY register number comes from access register bits 20 to 16.
// R11: Access register bits 15 to 0 carry the PHY register value.
// R12: Status bit 6 shows transmit pause, bit 5 receive pause.
// R13: Status bits 4, 3, 2 show gigabit full, 100 and 10 Mbps link.
// R14: Status bit 1 shows link up, bit 0 full duplex.
// R15: Status register refreshes continuously, each interval below 300 microseconds.
// R16: Receive size limit is a 14-bit field, at most 16K minus one.
// R17: Software must program a non-zero size limit, else nothing is received.
// R18: Packet longer than the limit sets oversize and error summary bits.
// R19: Oversized packet without frame check error still counts as good.
// R20: PHY status comes from polling six registers, 64 clocks of 320 ns each; the divider rounds up to 350 ns clocks.
// R21: Each PHY access is a serial management frame with its management clock.
`timescale 1ns/1ps
module wake_phy_access_regs #(
    parameter logic [4:0] PHY_ADDR     = 5'h01,
    parameter int         MDC_HALF_CYC = wake_phy_pkg::MDC_HALF_CYC
) (
    // Clock and reset.
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_reset_n,
    // Register bus.
    input  wire wake_phy_pkg::apb_req_s i_apb,
    output wake_phy_pkg::apb_rsp_s      o_apb,
    // Bus reset, power management event and EEPROM autoload.
    input  wire logic                   i_bus_reset,
    input  wire logic                   i_pm_event,
    input  wire logic                   i_eeprom_load,
    input  wire logic [7:0]             i_eeprom_cfg,
    output logic                        o_pm_flag,
    output logic                        o_lan_wake,
    // Wake frame classification.
    input  wire wake_phy_pkg::wake_frame_s i_wake_frame,
    output logic                        o_wake_hit,
    // Receive packet end and status.
    input  wire wake_phy_pkg::rx_end_s  i_rx_end,
    output wake_phy_pkg::rx_status_s    o_rx_status,
    output logic                        o_rx_enable,
    // Management pins.
    output logic                        o_mdc,
    input  wire logic                   i_mdio,
    output logic                        o_mdio,
    output logic                        o_mdio_oe_n
);
    localparam int DIV_W = $clog2(MDC_HALF_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MDC_HALF_CYC - 1);

    typedef struct packed {
        logic [2:0]                            wake_frame_en;
        logic                                  wake_sig_en;
        logic                                  pm_policy;
        logic                                  pm_flag;
        logic                                  lan_wake;
        logic                                  wake_hit;
        logic                                  phy_flag;
        logic [wake_phy_pkg::PHY_IDX_W-1:0]    phy_idx;
        logic [wake_phy_pkg::PHY_VAL_W-1:0]    phy_val;
        logic                                  sw_pend;
        logic                                  sw_wr;
        logic [wake_phy_pkg::LINK_STAT_W-1:0]  link_stat;
        logic [wake_phy_pkg::RX_SIZE_W-1:0]    size_lim;
        wake_phy_pkg::rx_status_s              rx_stat;
        wake_phy_pkg::mdio_e                   st;
        logic [5:0]                            bitcnt;
        logic [63:0]                           shift;
        logic [15:0]                           rd;
        logic                                  cur_sw;
        logic                                  cur_wr;
        logic [2:0]                            poll;
        logic [DIV_W-1:0]                      div;
        logic                                  mdc;
        logic                                  mdo;
        logic                                  oe_n;
        logic [2:0]                            mdi_sync;
        logic                                  mdi;
        logic [31:0]                           prdata;
        logic                                  pslverr;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic                 setup;
    logic                 wr_acc;
    logic [4:0]           poll_reg;
    logic [31:0]          rd_word;
    logic                 rd_hit;
    logic                 tick;
    logic                 start;
    logic                 start_wr;
    logic [4:0]           start_reg;

    assign setup  = i_apb.psel & ~i_apb.penable;
    assign wr_acc = i_apb.psel & i_apb.penable & i_apb.pwrite;
    assign tick   = (s_q.div == DIV_LAST);
    assign poll_reg = wake_phy_pkg::POLL_LIST[s_q.poll*5 +: 5];

    // Read mux, shared by the setup-phase capture.
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (i_apb.paddr)
            wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_WAKE_CONFIG):
            begin
                rd_word[wake_phy_pkg::BCAST_WAKE_BIT] = s_q.wake_frame_en[2];
                rd_word[wake_phy_pkg::MCAST_WAKE_BIT] = s_q.wake_frame_en[1];
                rd_word[wake_phy_pkg::UCAST_WAKE_BIT] = s_q.wake_frame_en[0];
                rd_word[wake_phy_pkg::WAKE_SIG_BIT]   = s_q.wake_sig_en;
                rd_word[wake_phy_pkg::PM_POLICY_BIT]  = s_q.pm_policy;
            end
            wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_PM_STATUS):
            begin
                rd_word[wake_phy_pkg::PM_FLAG_BIT] = s_q.pm_flag;
            end
            wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_PHY_ACCESS):
            begin
                rd_word[wake_phy_pkg::PHY_FLAG_BIT] = s_q.phy_flag;
                rd_word[wake_phy_pkg::PHY_IDX_LSB +: wake_phy_pkg::PHY_IDX_W] = s_q.phy_idx;
                rd_word[wake_phy_pkg::PHY_VAL_W-1:0] = s_q.phy_val; // [R11]
            end
            wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_PHY_STATUS):
            begin
                rd_word[wake_phy_pkg::LINK_STAT_W-1:0] = s_q.link_stat; // [R12] [R13] [R14]
            end
            wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_RX_SIZE):
            begin
                rd_word[wake_phy_pkg::RX_SIZE_W-1:0] = s_q.size_lim; // [R16]
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // A pending software access takes the next frame slot ahead of the poller.
    always_comb
    begin
        start     = (s_q.st == wake_phy_pkg::MDIO_IDLE);
        start_wr  = s_q.sw_pend & s_q.sw_wr;
        start_reg = s_q.sw_pend ? s_q.phy_idx : poll_reg; // [R10]
    end

    always_comb
    begin
        s_d = s_q;
        s_d.wake_hit = 1'b0;
        s_d.rx_stat  = '0;

        // Bus slave: read data is captured in the setup phase, answer in access phase.
        if (setup)
        begin
            s_d.prdata  = i_apb.pwrite ? 32'h00000000 : rd_word;
            s_d.pslverr = ~rd_hit;
        end
        if (wr_acc)
        begin
            case (i_apb.paddr)
                wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_WAKE_CONFIG):
                begin
                    s_d.wake_frame_en = {i_apb.pwdata[wake_phy_pkg::BCAST_WAKE_BIT],
                                         i_apb.pwdata[wake_phy_pkg::MCAST_WAKE_BIT],
                                         i_apb.pwdata[wake_phy_pkg::UCAST_WAKE_BIT]};
                    s_d.wake_sig_en = i_apb.pwdata[wake_phy_pkg::WAKE_SIG_BIT];
                    s_d.pm_policy   = i_apb.pwdata[wake_phy_pkg::PM_POLICY_BIT];
                end
                wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_PM_STATUS):
                begin
                    if (i_apb.pwdata[wake_phy_pkg::PM_FLAG_BIT])
                    begin
                        s_d.pm_flag = 1'b0; // [R6]
                    end
                end
                wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_PHY_ACCESS):
                begin
                    // A write while a software access is pending or in flight would corrupt it, so it is dropped.
                    if (!s_q.sw_pend && !s_q.cur_sw)
                    begin
                        s_d.phy_flag = i_apb.pwdata[wake_phy_pkg::PHY_FLAG_BIT];
                        s_d.sw_wr    = i_apb.pwdata[wake_phy_pkg::PHY_FLAG_BIT]; // [R8] [R9]
                        s_d.phy_idx  = i_apb.pwdata[wake_phy_pkg::PHY_IDX_LSB +:
                                                    wake_phy_pkg::PHY_IDX_W]; // [R10]
                        s_d.phy_val  = i_apb.pwdata[wake_phy_pkg::PHY_VAL_W-1:0]; // [R11]
                        s_d.sw_pend  = 1'b1;
                    end
                end
                wake_phy_pkg::reg_addr(wake_phy_pkg::IDX_RX_SIZE):
                begin
                    s_d.size_lim = i_apb.pwdata[wake_phy_pkg::RX_SIZE_W-1:0]; // [R16]
                end
                default:
                begin
                end
            endcase
        end

        // Autoload overrides a software write in the same cycle.
        if (i_eeprom_load)
        begin
            s_d.wake_sig_en = i_eeprom_cfg[wake_phy_pkg::WAKE_SIG_BIT]; // [R7]
            s_d.pm_policy   = i_eeprom_cfg[wake_phy_pkg::PM_POLICY_BIT]; // [R7]
        end

        // Power management flag: bus reset clears only under the policy bit.
        if (i_bus_reset && s_q.pm_policy)
        begin
            s_d.pm_flag = 1'b0; // [R6]
        end
        if (i_pm_event || s_q.wake_hit)
        begin
            s_d.pm_flag = 1'b1;
        end
        s_d.lan_wake = s_q.wake_sig_en & s_q.pm_flag; // [R5]

        // Wake frame filter.
        if (i_wake_frame.valid && i_wake_frame.mask_dest_only)
        begin
            s_d.wake_hit = (i_wake_frame.dest_bcast & s_q.wake_frame_en[2])  // [R1]
                         | (i_wake_frame.dest_mcast & s_q.wake_frame_en[1])  // [R2]
                         | (i_wake_frame.dest_own   & s_q.wake_frame_en[0]); // [R3]
        end

        // Receive size check.
        if (i_rx_end.done)
        begin
            s_d.rx_stat.valid       = 1'b1;
            s_d.rx_stat.oversize    = (i_rx_end.len > s_q.size_lim); // [R18]
            s_d.rx_stat.err_summary = (i_rx_end.len > s_q.size_lim) | i_rx_end.crc_err; // [R18]
            s_d.rx_stat.good        = ~i_rx_end.crc_err; // [R19]
        end

        // Management input: three stages, a change counts when the last two agree.
        s_d.mdi_sync = {s_q.mdi_sync[1:0], i_mdio};
        if (s_q.mdi_sync[1] == s_q.mdi_sync[2])
        begin
            s_d.mdi = s_q.mdi_sync[2];
        end

        // Management clock divider, one half period per tick.
        s_d.div = tick ? '0 : s_q.div + DIV_W'(1);

        case (s_q.st)
            wake_phy_pkg::MDIO_IDLE:
            begin
                if (start)
                begin
                    s_d.shift  = wake_phy_pkg::mdio_frame(start_wr, PHY_ADDR, start_reg,
                                                          s_q.phy_val); // [R21]
                    s_d.cur_sw = s_q.sw_pend;
                    s_d.cur_wr = start_wr;
                    s_d.sw_pend = s_d.sw_pend & ~s_q.sw_pend;
                    s_d.bitcnt = '0;
                    s_d.mdo    = 1'b1;
                    s_d.oe_n   = 1'b0;
                    s_d.mdc    = 1'b0;
                    s_d.div    = '0;
                    s_d.st     = wake_phy_pkg::MDIO_SHIFT;
                end
            end
            wake_phy_pkg::MDIO_SHIFT:
            begin
                if (tick && !s_q.mdc)
                begin
                    s_d.mdc = 1'b1;
                    if (!s_q.cur_wr && s_q.bitcnt >= wake_phy_pkg::BIT_DATA)
                    begin
                        s_d.rd = {s_q.rd[14:0], s_q.mdi};
                    end
                end
                else if (tick)
                begin
                    s_d.mdc = 1'b0;
                    if (s_q.bitcnt == wake_phy_pkg::BIT_LAST)
                    begin
                        s_d.oe_n = 1'b1;
                        s_d.st   = wake_phy_pkg::MDIO_DONE;
                    end
                    else
                    begin
                        s_d.bitcnt = s_q.bitcnt + 6'h01;
                        s_d.shift  = {s_q.shift[62:0], 1'b0};
                        s_d.mdo    = s_q.shift[62];
                        s_d.oe_n   = ~(s_q.cur_wr
                            | (s_q.bitcnt + 6'h01 < wake_phy_pkg::BIT_RD_DRIVE));
                    end
                end
            end
            wake_phy_pkg::MDIO_DONE:
            begin
                s_d.st = wake_phy_pkg::MDIO_IDLE;
                if (s_q.cur_sw)
                begin
                    s_d.cur_sw = 1'b0;
                    if (s_q.cur_wr)
                    begin
                        s_d.phy_flag = 1'b0; // [R8]
                    end
                    else
                    begin
                        s_d.phy_flag = 1'b1; // [R9]
                        s_d.phy_val  = s_q.rd; // [R11]
                    end
                end
                else
                begin
                    // Six back-to-back reads keep each refresh well inside the limit.
                    if (s_q.poll == wake_phy_pkg::POLL_STATUS_SLOT)
                    begin
                        s_d.link_stat = s_q.rd[wake_phy_pkg::LINK_STAT_W-1:0]; // [R15]
                    end
                    s_d.poll = (s_q.poll == wake_phy_pkg::POLL_LAST_SLOT) ? 3'h0
                             : s_q.poll + 3'h1; // [R20]
                end
            end
            default:
            begin
                s_d.st = wake_phy_pkg::MDIO_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s_q      <= '0; // [R4]
            s_q.oe_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_apb.prdata  = s_q.prdata;
    assign o_apb.pready  = i_apb.psel & i_apb.penable;
    assign o_apb.pslverr = i_apb.psel & i_apb.penable & s_q.pslverr;
    assign o_pm_flag     = s_q.pm_flag;
    assign o_lan_wake    = s_q.lan_wake; // [R5]
    assign o_wake_hit    = s_q.wake_hit;
    assign o_rx_status   = s_q.rx_stat;
    assign o_rx_enable   = (s_q.size_lim != '0); // [R17]
    assign o_mdc         = s_q.mdc;
    assign o_mdio        = s_q.mdo;
    assign o_mdio_oe_n   = s_q.oe_n;
endmodule

// ==== testbench/wake_phy_asserts.sv ====
`timescale 1ns/1ps
module wake_phy_asserts #(
    parameter int MDC_HALF_CYC = wake_phy_pkg::MDC_HALF_CYC
) (
    // Watched ports.
    input wire logic                      i_sys_clk,
    input wire logic                      i_reset_n,
    input wire logic                      i_pm_event,
    input wire wake_phy_pkg::wake_frame_s i_wake_frame,
    input wire wake_phy_pkg::rx_end_s     i_rx_end,
    input wire wake_phy_pkg::rx_status_s  o_rx_status,
    input wire logic                      o_pm_flag,
    input wire logic                      o_lan_wake,
    input wire logic                      o_wake_hit,
    input wire logic                      o_mdc,
    input wire logic                      o_mdio,
    input wire logic                      o_mdio_oe_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // Counts the high phase, since a repetition cannot take the parameter as its count.
    logic [7:0] mdc_high_q;
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
        if (!i_reset_n)
            mdc_high_q <= 8'h00;
        else
            mdc_high_q <= o_mdc ? mdc_high_q + 8'h01 : 8'h00;
    sequence s_rx_done;
        i_rx_end.done ##1 o_rx_status.valid;
    endsequence
    a_wake_hit_cause: assert property (o_wake_hit |-> $past(i_wake_frame.mask_dest_only))
        else $error("wake hit without a destination-only frame");
    a_wake_sets_flag: assert property (o_wake_hit |-> ##[0:1] o_pm_flag)
        else $error("wake hit left status flag clear");
    a_event_sets_flag: assert property (i_pm_event |=> o_pm_flag)
        else $error("power event left status flag clear");
    a_lan_wake_gate: assert property (o_lan_wake |-> $past(o_pm_flag))
        else $error("wake output without status flag");
    a_rx_good_pulse: assert property (i_rx_end.done |=> o_rx_status.valid
        && o_rx_status.good == !$past(i_rx_end.crc_err))
        else $error("receive status pulse or good bit wrong");
    a_rx_err_sum: assert property (s_rx_done |-> o_rx_status.err_summary
        == (o_rx_status.oversize || $past(i_rx_end.crc_err)))
        else $error("error summary wrong");
    a_mdc_half: assert property ($fell(o_mdc) |-> mdc_high_q == MDC_HALF_CYC)
        else $error("management clock high phase wrong");
    a_frame_start: assert property ($fell(o_mdio_oe_n) |-> o_mdio && !o_mdc)
        else $error("frame does not open with preamble");
endmodule
bind wake_phy_access_regs wake_phy_asserts #(.MDC_HALF_CYC(MDC_HALF_CYC)) u_chk (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_pm_event(i_pm_event),
    .i_wake_frame(i_wake_frame), .i_rx_end(i_rx_end), .o_rx_status(o_rx_status),
    .o_pm_flag(o_pm_flag), .o_lan_wake(o_lan_wake), .o_wake_hit(o_wake_hit),
    .o_mdc(o_mdc), .o_mdio(o_mdio), .o_mdio_oe_n(o_mdio_oe_n));

// ==== testbench/mdio_phy_model.sv ====
`timescale 1ns/1ps
module mdio_phy_model #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    // Management pins.
    input  wire logic i_mdc,
    input  wire logic i_mdio,
    output logic      o_mdio,
    output logic      o_mdio_oe_n
);
    logic [15:0] regs [32];
    logic [15:0] sh = 16'h0000;
    logic [15:0] rd_val = 16'h0000;
    logic [4:0]  wa = 5'h00;
    logic        busy = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    int          ones = 0;
    int          k = 0;
    // Frames are found by preamble and the leading zero start bit alone, as a real device must.
    always @(posedge i_mdc)
    begin
        k = busy ? k + 1 : 0;
        sh = {sh[14:0], i_mdio};
        busy = busy || (!i_mdio && ones >= 32);
        ones = i_mdio ? ones + 1 : 0;
        if (k == 13)
        begin
            rd = sh[11:10] == 2'h2 && sh[9:5] == PHY_ADDR;
            wr = sh[11:10] == 2'h1 && sh[9:5] == PHY_ADDR;
            wa = sh[4:0];
            rd_val = regs[sh[4:0]];
        end
        if (k == 31)
        begin
            if (wr)
                regs[wa] = sh;
            {busy, rd, wr, ones} = '0;
        end
    end
    always @(negedge i_mdc)
    begin
        o_mdio_oe_n = !(rd && k >= 14 && k < 31);
        o_mdio = k == 14 ? 1'b0 : rd_val[4'(30 - k)];
    end
    initial
    begin
        {o_mdio, o_mdio_oe_n} = 2'h1;
        foreach (regs[i]) regs[i] = 16'h0000;
    end
endmodule

// ==== testbench/tb_wake_phy_access_regs.sv ====
`timescale 1ns/1ps
module tb_wake_phy_access_regs;
    localparam int HALF = wake_phy_pkg::MDC_HALF_CYC;
    logic                      clk, rst_n, pm_flag, lan_wake, hit, rx_en, e;
    logic                      mdc, mdo, mdo_oe_n, phy_do, phy_oe_n, mdio_w;
    logic [2:0]                strb, en;
    logic [7:0]                ee_cfg;
    logic [4:0]                r;
    logic [13:0]               lim;
    logic [31:0]               q, v;
    wake_phy_pkg::apb_req_s    req;
    wake_phy_pkg::apb_rsp_s    rsp;
    wake_phy_pkg::wake_frame_s wf;
    wake_phy_pkg::rx_end_s     rx;
    wake_phy_pkg::rx_status_s  rs;
    int                        error_cnt = 0;
    int                        n_compared = 0;
    // The data line has a pull-up, so it reads high when neither end drives it.
    assign mdio_w = !mdo_oe_n ? mdo : !phy_oe_n ? phy_do : 1'b1;
    wake_phy_access_regs #(.MDC_HALF_CYC(HALF)) u_dut (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_apb(req), .o_apb(rsp), .i_bus_reset(strb[0]),
        .i_pm_event(strb[1]), .i_eeprom_load(strb[2]), .i_eeprom_cfg(ee_cfg),
        .o_pm_flag(pm_flag), .o_lan_wake(lan_wake), .i_wake_frame(wf), .o_wake_hit(hit),
        .i_rx_end(rx), .o_rx_status(rs), .o_rx_enable(rx_en), .o_mdc(mdc), .i_mdio(mdio_w),
        .o_mdio(mdo), .o_mdio_oe_n(mdo_oe_n));
    mdio_phy_model u_phy (.i_mdc(mdc), .i_mdio(mdio_w), .o_mdio(phy_do), .o_mdio_oe_n(phy_oe_n));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
            @(posedge clk);
        while (rsp.pready !== 1'b1 && n++ < 20);
        if (rsp.pready !== 1'b1) error_cnt++;
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
    task automatic poll(input logic f);
        int n;
        n = 0;
        do
            apb(1'b0, 12'h180, 32'h0);
        while (q[31] !== f && n++ < 2000);
        chk(q[31], f);
    endtask
    task automatic pulse(input logic [2:0] s);
        @(posedge clk);
        strb <= s;
        @(posedge clk);
        strb <= 3'h0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("TB: %0d compared, %0d mismatched", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        #1500000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        {rst_n, strb, ee_cfg, req, wf, rx} = '0;
        void'($urandom(32'ha1050700));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h158, 32'h0);
        chk(q, 32'h0);
        chk(rx_en, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h0);
        chk(e, 32'h1);
        $display("reset and decode test done");
        repeat (4)
        begin
            en = 3'($urandom);
            apb(1'b1, 12'h158, {25'h0, en, 4'h0});
            apb(1'b0, 12'h158, 32'h0);
            chk(q, {25'h0, en, 4'h0});
            for (int c = 0; c < 4; c++)
            begin
                @(posedge clk);
                wf <= {1'b1, c != 3, c < 3 ? 3'b100 >> c : 3'b111};
                @(posedge clk);
                wf <= '0;
                @(negedge clk);
                chk(hit, c < 3 ? en[2 - c] : 1'b0);
            end
        end
        pulse(3'h2);
        apb(1'b1, 12'h158, 32'h0);
        repeat (2) @(negedge clk);
        chk(lan_wake, 32'h0);
        apb(1'b1, 12'h158, 32'h2);
        repeat (2) @(negedge clk);
        chk(lan_wake, 32'h1);
        apb(1'b1, 12'h158, 32'h0);
        pulse(3'h1);
        chk(pm_flag, 32'h1);
        apb(1'b1, 12'h158, 32'h1);
        pulse(3'h1);
        chk(pm_flag, 32'h0);
        pulse(3'h2);
        apb(1'b1, 12'h160, 32'h1);
        @(negedge clk);
        chk(pm_flag, 32'h0);
        v = $urandom;
        ee_cfg = v[7:0];
        pulse(3'h4);
        apb(1'b0, 12'h158, 32'h0);
        chk(q, {30'h0, v[1:0]});
        $display("wake and status flag test done");
        repeat (3)
        begin
            r = 5'($urandom);
            v = $urandom;
            apb(1'b1, 12'h180, {11'h400, r, v[15:0]});
            poll(1'b0);
            chk(u_phy.regs[r], v[15:0]);
            v = $urandom;
            u_phy.regs[r] = v[15:0];
            apb(1'b1, 12'h180, {11'h0, r, 16'h0});
            poll(1'b1);
            chk(q, {11'h400, r, v[15:0]});
        end
        v = $urandom;
        u_phy.regs[5'h11] = v[15:0];
        repeat (7000) @(posedge clk);
        apb(1'b0, 12'h1b0, 32'h0);
        chk(q, {25'h0, v[6:0]});
        $display("phy access test done");
        apb(1'b1, 12'h368, 32'hffffffff);
        apb(1'b0, 12'h368, 32'h0);
        chk(q, 32'h3fff);
        lim = 14'($urandom_range(16382, 1));
        apb(1'b1, 12'h368, {18'h0, lim});
        @(negedge clk);
        chk(rx_en, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            rx <= {1'b1, lim + 14'(k[1]), k[0]};
            @(posedge clk);
            rx <= '0;
            @(negedge clk);
            chk(rs, {1'b1, k[1], k[1] | k[0], !k[0]});
        end
        $display("receive size test done");
        tally_and_finish();
    end
endmodule
